// ---- logic/dac_params.svh ----
// constants of the toggle and thermal control block
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH

// sizes
`define DATA_W 14
`define BUS_W 16
`define ADDR_W 6
`define NUM_CH 16
`define GROUP_SIZE 8
`define EV_W 3

// address fields: [5:4] register select, [3:0] channel address bits
`define SEL_SPECIAL 2'h0
`define SEL_B 2'h2
`define SEL_A 2'h3
`define CH_CTRL 4'hC
`define CH_STATUS 4'h1
`define CH_MASK 4'h2
`define CH_POWER 4'h3

// control and power register field positions, wide and narrow variants
`define TOG_LO_BIT 2
`define TOG_HI_BIT 3
`define TOG_LO_BIT_12B 0
`define TOG_HI_BIT_12B 1
`define MON_BIT 8
`define MON_BIT_12B 6
`define PWR_UP_BIT 0

// event bits of the status register
`define EV_THERMAL 0
`define EV_UPDATE 1
`define EV_B_DROP 2

// reset values
`define CTRL_RESET 16'h0000
`define MASK_RESET 3'h0
`define CODE_RESET 14'h0000

`endif

// ---- logic/dac_pkg.sv ----
// types shared by the toggle and thermal control block
package dac_pkg;
  `include "dac_params.svh"

  typedef logic [`DATA_W-1:0] code_t;
  typedef logic [`BUS_W-1:0] word_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`EV_W-1:0] event_t;

  typedef enum logic [1:0] {
    TH_RUN = 2'b01,
    TH_SHUT = 2'b10
  } thermal_state_t;
endpackage

// ---- logic/chan_wr_if.sv ----
// channel write and update signals from the decoder to each channel
`timescale 1ns/1ns
interface chan_wr_if;
  import dac_pkg::*;
  logic wr_a;
  logic wr_b;
  logic [3:0] chan;
  code_t data;
  logic update;
  logic [1:0] toggle_en;

  modport source (output wr_a, wr_b, chan, data, update, toggle_en);
  modport sink (input wr_a, wr_b, chan, data, update, toggle_en);
endinterface

// ---- logic/dac_channel.sv ----
// one converter channel: A and B data registers and its converter register
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_channel #(
  parameter int CH = 0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // decoder side
  chan_wr_if.sink bus,
  // state
  output dac_pkg::code_t code_a,
  output dac_pkg::code_t code_b,
  output dac_pkg::code_t dac_code,
  output logic phase_b
);
  import dac_pkg::*;

  localparam int GROUP = CH / `GROUP_SIZE;

  // channel selection and toggle enable of this channel's group
  wire hit = (bus.chan == 4'(CH));
  wire tog = bus.toggle_en[GROUP];

  // RL3 two data registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      code_a <= `CODE_RESET;
    end else if (bus.wr_a && hit) begin
      code_a <= bus.data;
    end
  end

  // RL4 B write needs toggle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      code_b <= `CODE_RESET;
    end else if (bus.wr_b && hit && tog) begin
      code_b <= bus.data;
    end
  end

  // RL6 strobe alternates A/B; RL7 first strobe loads A; RL9 off means A
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dac_code <= `CODE_RESET;
      phase_b <= 1'b0;
    end else if (bus.update) begin
      dac_code <= (tog && phase_b) ? code_b : code_a;
      phase_b <= tog && !phase_b;
    end else if (!tog) begin
      phase_b <= 1'b0; // next enable starts again from A
    end
  end
endmodule // dac_channel

// ---- logic/thermal_guard.sv ----
// over-temperature shutdown latch with its recovery paths
`timescale 1ns/1ns
module thermal_guard (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic monitor_en,
  input wire logic over_temp,
  input wire logic soft_power_up,
  // state
  output logic amps_down,
  output logic trip
);
  import dac_pkg::*;

  thermal_state_t state_reg;
  thermal_state_t state_next;

  // next state of the shutdown latch
  always_comb begin
    state_next = state_reg;
    trip = 1'b0;
    case (state_reg)
      TH_RUN: begin
        // RL11 trip on heat; RL13 only when monitor on
        if (monitor_en && over_temp) begin
          state_next = TH_SHUT;
          trip = 1'b1;
        end
      end
      TH_SHUT: begin
        // RL12 recover by power-up when cool or monitor off
        if (!monitor_en || (soft_power_up && !over_temp)) begin
          state_next = TH_RUN;
        end
      end
      default: state_next = TH_RUN;
    endcase
  end

  // RL13 latched until recovery
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= TH_RUN;
      amps_down <= 1'b0;
    end else begin
      state_reg <= state_next;
      amps_down <= (state_next == TH_SHUT);
    end
  end
endmodule // thermal_guard

// ---- logic/dac_toggle_thermal_ctrl.sv ----
// register decoder, toggle control and thermal path of the converter
`timescale 1ns/1ns
`include "dac_params.svh"
// Functional notes
// RL1: control write when register select is 00 and channel address is 1100.
// RL2: toggle enabled per eight-channel group by bits 3/2, or 1/0 narrow.
// RL3: each channel keeps separate A and B data registers.
// RL4: B register writes only take effect while its group toggles.
// RL5: host enables toggle, loads A, loads B, then strobes update.
// RL6: in toggle mode each update strobe alternates output between A and B.
// RL7: first update strobe after configuring toggle loads the A values.
// RL8: host sets square wave frequency by its update strobe rate.
// RL9: after toggle turns off, next strobe loads A and alternation stops.
// RL10: monitor enabled by control bit 8, or bit 6 on narrow variant.
// RL11: monitor on and die too hot powers down all amplifiers.
// RL12: power-up when cool or monitor off re-enables amplifiers.
// RL13: shutdown stays latched until recovery; none while monitor off.
module dac_toggle_thermal_ctrl #(
  parameter bit NARROW_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire dac_pkg::addr_t addr,
  input wire dac_pkg::word_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output dac_pkg::word_t rdata,
  // pins
  input wire logic output_update_strobe_n,
  input wire logic over_temp,
  // converter side
  output logic [`NUM_CH*`DATA_W-1:0] dac_code,
  output logic amps_powered_down,
  output logic irq
);
  import dac_pkg::*;

  chan_wr_if bus ();

  word_t ctrl_reg;
  event_t status_reg;
  event_t status_next;
  event_t mask_reg;
  word_t rdata_reg;
  logic irq_reg;
  logic strobe_n_reg;
  code_t code_a [`NUM_CH];
  code_t code_b [`NUM_CH];
  logic [`NUM_CH-1:0] phase_b;
  logic amps_down;
  logic trip;

  // address fields
  wire [1:0] sel = addr[5:4];
  wire [3:0] chan = addr[3:0];
  wire special_function_write = (sel == `SEL_SPECIAL);
  // RL1 control write decode
  wire hit_ctrl = special_function_write && (chan == `CH_CTRL);
  wire hit_status = special_function_write && (chan == `CH_STATUS);
  wire hit_mask = special_function_write && (chan == `CH_MASK);
  wire hit_power = special_function_write && (chan == `CH_POWER);
  wire hit_a = (sel == `SEL_A);
  wire hit_b = (sel == `SEL_B);

  // RL2 group enables; RL10 monitor enable, by variant
  wire tog_hi = NARROW_VARIANT ? ctrl_reg[`TOG_HI_BIT_12B]
                               : ctrl_reg[`TOG_HI_BIT];
  wire tog_lo = NARROW_VARIANT ? ctrl_reg[`TOG_LO_BIT_12B]
                               : ctrl_reg[`TOG_LO_BIT];
  wire monitor_en = NARROW_VARIANT ? ctrl_reg[`MON_BIT_12B]
                                   : ctrl_reg[`MON_BIT];

  // falling edge of the active-low update strobe
  wire update = strobe_n_reg && !output_update_strobe_n;
  wire soft_power_up = wr_en && hit_power && wdata[`PWR_UP_BIT];
  wire grp_of_b = chan[3] ? tog_hi : tog_lo;
  wire b_drop = wr_en && hit_b && !grp_of_b;

  // drive the channel bus
  assign bus.wr_a = wr_en && hit_a;
  assign bus.wr_b = wr_en && hit_b;
  assign bus.chan = chan;
  assign bus.data = wdata[`DATA_W-1:0];
  assign bus.update = update;
  assign bus.toggle_en = {tog_hi, tog_lo};

  // one channel per converter output
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++) begin : gen_ch
      dac_channel #(.CH(g)) u_ch (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(bus),
        .code_a(code_a[g]),
        .code_b(code_b[g]),
        .dac_code(dac_code[g*`DATA_W +: `DATA_W]),
        .phase_b(phase_b[g])
      );
    end
  endgenerate

  // RL11 shutdown latch and RL12 recovery
  thermal_guard u_thermal (
    .ref_clk(ref_clk),
    .rst(rst),
    .monitor_en(monitor_en),
    .over_temp(over_temp),
    .soft_power_up(soft_power_up),
    .amps_down(amps_down),
    .trip(trip)
  );

  assign amps_powered_down = amps_down;

  // status: events set, a read clears, a set wins over the clear
  wire event_t events = {b_drop, update, trip};
  wire status_rd = rd_en && hit_status;
  assign status_next = (status_rd ? `EV_W'(0) : status_reg) | events;

  // readback selection
  wire [`BUS_W-1:0] rd_thermal = {{(`BUS_W-2){1'b0}}, phase_b[0], amps_down};
  wire [`BUS_W-1:0] rd_mux =
    hit_a ? `BUS_W'(code_a[chan]) :
    hit_b ? `BUS_W'(code_b[chan]) :
    hit_ctrl ? ctrl_reg :
    hit_status ? `BUS_W'(status_reg) :
    hit_mask ? `BUS_W'(mask_reg) :
    hit_power ? rd_thermal : 16'h0000;

  // RL1 control register write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      ctrl_reg <= wdata;
    end
  end

  // mask register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= `MASK_RESET;
    end else if (wr_en && hit_mask) begin
      mask_reg <= wdata[`EV_W-1:0];
    end
  end

  // strobe history, status, interrupt and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strobe_n_reg <= 1'b1;
      status_reg <= `MASK_RESET;
      irq_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      strobe_n_reg <= output_update_strobe_n;
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
      rdata_reg <= rd_en ? rd_mux : 16'h0000;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
endmodule // dac_toggle_thermal_ctrl

// ---- verification/dac_toggle_thermal_ctrl_properties.sv ----
// port-level checks of the toggle and thermal control block
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_ctrl_props #(
  parameter bit NARROW_VARIANT = 1'h0
) (
  // clock, reset and register port
  input wire logic ref_clk,
  input wire logic rst,
  input wire dac_pkg::addr_t addr,
  input wire dac_pkg::word_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire dac_pkg::word_t rdata,
  // pins and converter side
  input wire logic output_update_strobe_n,
  input wire logic over_temp,
  input wire logic [`NUM_CH*`DATA_W-1:0] dac_code,
  input wire logic amps_powered_down,
  input wire logic irq
);
  import dac_pkg::*;
  word_t ctrl_reg;
  logic mask_zero_reg, mon, dn, sn;
  // shadows of control and mask writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 16'h0000;
      mask_zero_reg <= 1'h1;
    end else if (wr_en && addr == 6'h0C) begin
      ctrl_reg <= wdata;
    end else if (wr_en && addr == 6'h02) begin
      mask_zero_reg <= wdata[2:0] == 3'h0;
    end
  end
  // short names
  assign mon = ctrl_reg[NARROW_VARIANT ? 6 : 8];
  assign dn = amps_powered_down;
  assign sn = output_update_strobe_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_pwr_up;
    wr_en && addr == 6'h03 && wdata[0] && !over_temp && dn;
  endsequence
  property p_shut; mon && over_temp |-> ##[1:3] dn; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_nomon; $rose(dn) |-> $past(mon); endproperty
  a_nomon: assert property (p_nomon) else $error("trip unarmed");
  property p_latch;
    dn && mon && !wr_en && !$past(wr_en) && !$past(wr_en, 2) |=> dn;
  endproperty
  a_latch: assert property (p_latch) else $error("shutdown lost");
  property p_recover; s_pwr_up |-> ##[1:3] !dn; endproperty
  a_recover: assert property (p_recover) else $error("no restart");
  property p_ctrl_rd; rd_en && addr == 6'h0C |=> rdata == ctrl_reg;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
  property p_rd_idle; !$past(rd_en) |-> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_update; $changed(dac_code) |-> !$past(sn) && $past(sn, 2);
  endproperty
  a_update: assert property (p_update) else $error("stray update");
  property p_irq_off; mask_zero_reg && $past(mask_zero_reg) |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq masked");
endmodule // dac_ctrl_props

bind dac_toggle_thermal_ctrl dac_ctrl_props #(
  .NARROW_VARIANT(NARROW_VARIANT)
) u_dac_ctrl_props (.ref_clk, .rst, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .output_update_strobe_n, .over_temp, .dac_code,
  .amps_powered_down, .irq);

// ---- verification/host_strobe.sv ----
// host model that pulses the active-low update strobe
`timescale 1ns/1ns
module host_strobe (
  // clock, reset and request
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fire,
  // strobe pin
  output logic output_update_strobe_n
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_update_strobe_n <= 1'h1;
    end else begin
      output_update_strobe_n <= ~fire;
    end
  end
endmodule // host_strobe

// ---- verification/dac_toggle_thermal_ctrl_bench.sv ----
// self-checking bench of the toggle and thermal control block
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_toggle_thermal_ctrl_bench;
  import dac_pkg::*;
  logic ref_clk = 0, rst = 1, wr_en = 0, rd_en = 0, over_temp = 0;
  logic fire = 0, output_update_strobe_n, amps_powered_down, irq;
  addr_t addr = '0;
  word_t wdata = '0, rdata;
  logic [`NUM_CH*`DATA_W-1:0] dac_code;
  int n_mismatch = 0, checked = 0, ctrl = 0, st = 0, mask = 0;
  int a[16], b[16], ph[16];
  // clock
  always #10 ref_clk = ~ref_clk;
  dac_toggle_thermal_ctrl u_dac_toggle_thermal_ctrl (.ref_clk, .rst,
    .addr, .wdata, .wr_en, .rd_en, .rdata, .output_update_strobe_n,
    .over_temp, .dac_code, .amps_powered_down, .irq);
  host_strobe u_host_strobe (.ref_clk, .rst, .fire,
    .output_update_strobe_n);
  // compare and count
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // register write, model follows; an idle edge keeps writes apart
  task automatic wr(addr_t ad, word_t d);
    if (ad == 6'h0C) ctrl = d;
    if (ad == 6'h02) mask = d;
    if (ad[5:4] == 2'h3) a[ad[3:0]] = d;
    // B kept only while its group toggles
    if (ad[5:4] == 2'h2 && ctrl[2 + ad[3]]) b[ad[3:0]] = d;
    else if (ad[5:4] == 2'h2) st |= 4;
    addr <= ad;
    wdata <= d;
    wr_en <= 1'h1;
    step(1);
    wr_en <= 1'h0;
    step(1);
  endtask
  // register read, data stands the cycle after
  task automatic rd(addr_t ad, word_t exp);
    addr <= ad;
    rd_en <= 1'h1;
    step(1);
    rd_en <= 1'h0;
    #1 chk("rdata", rdata, exp);
    if (ad == 6'h01) st = 0;
    step(1);
  endtask
  // strobe through the host, then compare every channel
  task automatic strobe(int gap);
    int c;
    fire <= 1'h1;
    step(1);
    fire <= 1'h0;
    step(5 + gap);
    st |= 2;
    #1;
    for (int i = 0; i < 16; i++) begin
      // A first, then B while toggling
      c = ctrl[2 + i / 8] && ph[i] ? b[i] : a[i];
      ph[i] = ctrl[2 + i / 8] && !ph[i];
      chk("dac", dac_code[i*14+:14], 16'(c));
    end
    chk("irq", irq, 16'((st & mask) != 0));
    step(1);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h09B71728));
    step(3);
    rst <= 1'h0;
    #1 chk("irq", irq, 1'h0);
    step(1);
    wr(6'h02, 16'h0007);
    wr(6'h0C, 16'h0004);
    rd(6'h0C, 16'h0004);
    rd(6'h1C, 16'h0000);
    for (int i = 0; i < 32; i++)
      wr({i < 16 ? 2'h3 : 2'h2, 4'(i)}, word_t'($urandom & 32'h3FFF));
    rd(6'h01, 16'h0004);
    for (int k = 0; k < 3; k++) strobe(k);
    wr(6'h0C, 16'h000C);
    wr(6'h2F, word_t'($urandom & 32'h3FFF));
    strobe(0);
    strobe(2);
    wr(6'h0C, 16'h0000);
    strobe(0);
    strobe(1);
    wr(6'h02, 16'h0000);
    wr(6'h0C, 16'h000C);
    strobe(0);
    wr(6'h0C, 16'h0100);
    over_temp <= 1'h1;
    step(4);
    chk("amps", amps_powered_down, 1'h1);
    rd(6'h03, 16'h0001);
    wr(6'h03, 16'h0001);
    step(2);
    chk("amps", amps_powered_down, 1'h1);
    over_temp <= 1'h0;
    step(4);
    chk("amps", amps_powered_down, 1'h1);
    wr(6'h03, 16'h0001);
    step(3);
    chk("amps", amps_powered_down, 1'h0);
    st |= 1;
    rd(6'h01, word_t'(st));
    over_temp <= 1'h1;
    step(4);
    wr(6'h0C, 16'h0000);
    step(3);
    chk("amps", amps_powered_down, 1'h0);
    step(4);
    chk("amps", amps_powered_down, 1'h0);
    end_sim();
  end
endmodule // dac_toggle_thermal_ctrl_bench
